// file: core/general_pin_seven_output_source_mux.sv
`timescale 1ns/1ns
`include "pin7_regs.svh"
// What this block does
// - Bits 4:2 pick the source: ports 0-3, device status, or transmit port.
// - Bits 7:5 pick the data within the chosen source group.
// - Receive port selects 000-011 carry remote pins 0-3 of that port.
// - Receive port selects 100-111 carry lock, pass, frame and line valid.
// - Device status: 001 OR lock, 010 AND lock, 011 AND pass, 100 frame sync.
// - For device status, select 000 drives the local value bit.
// - Transmit: 000 AND pass, 001 OR pass, 010 frame, 011 line, 101 irq.
// - For transmit, 100 drives the multi-port sync flag and 111 is reserved.
// - Bit 1 is the local value and bit 0 enables the pin output.
// - The control register sits at 0x17 and resets to all zeros.
module general_pin_seven_output_source_mux (
    input  wire logic       core_clk_i,
    input  wire logic       arst_n_i,
    input  wire logic [7:0] reg_addr_i,
    input  wire logic [7:0] reg_wdata_i,
    input  wire logic       reg_write_i,
    input  wire logic       reg_read_i,
    output logic      [7:0] reg_rdata_o,
    input  wire logic [3:0] port_enable_i,
    input  wire logic [3:0] pass_select_i,
    input  wire logic [3:0] rx_remote_pin0_i,
    input  wire logic [3:0] rx_remote_pin1_i,
    input  wire logic [3:0] rx_remote_pin2_i,
    input  wire logic [3:0] rx_remote_pin3_i,
    input  wire logic [3:0] rx_lock_i,
    input  wire logic [3:0] rx_pass_i,
    input  wire logic [3:0] rx_frame_valid_i,
    input  wire logic [3:0] rx_line_valid_i,
    input  wire logic       frame_sync_signal_i,
    input  wire logic       tx_frame_valid_i,
    input  wire logic       tx_line_valid_i,
    input  wire logic       tx_synced_i,
    input  wire logic       tx_interrupt_i,
    output logic            general_pin_seven_o,
    output logic            general_pin_seven_oe_o
);

    // ****************************************
    // Control register
    // ****************************************
    logic [7:0] pin7_output_control_r;
    logic       ctl_hit;
    logic       rd_hit_r;

    assign ctl_hit = (reg_addr_i == `PIN7_CTL_ADDR);

    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pin7_output_control_r <= `PIN7_CTL_RESET;
        end else if (reg_write_i && ctl_hit) begin
            pin7_output_control_r <= reg_wdata_i;
        end
    end

    // Unmapped reads return zero
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rd_hit_r    <= 1'b0;
            reg_rdata_o <= 8'h00;
        end else begin
            rd_hit_r    <= reg_read_i && ctl_hit;
            reg_rdata_o <= (reg_read_i && ctl_hit) ?
                           pin7_output_control_r : 8'h00;
        end
    end

    // ****************************************
    // Field decode
    // ****************************************
    pin7_pkg::data_select_t  pin7_data_select;
    pin7_pkg::source_group_e pin7_source_group;
    logic                    pin7_local_value;
    logic                    pin7_output_enable;

    assign pin7_data_select   =
        pin7_output_control_r[`PIN7_SEL_MSB:`PIN7_SEL_LSB];
    assign pin7_source_group  = pin7_pkg::source_group_e'(
        pin7_output_control_r[`PIN7_SRC_MSB:`PIN7_SRC_LSB]);
    assign pin7_local_value   = pin7_output_control_r[`PIN7_VAL_BIT];
    assign pin7_output_enable = pin7_output_control_r[`PIN7_EN_BIT];

    // ****************************************
    // Input synchronisers
    // ****************************************
    // All status arrives from other domains or pins; two flops each.
    localparam int NSYNC = 45;
    logic [NSYNC-1:0] sync_in;
    logic [NSYNC-1:0] sync_q1_r;
    logic [NSYNC-1:0] sync_q2_r;

    assign sync_in = {port_enable_i, pass_select_i, rx_remote_pin0_i,
                      rx_remote_pin1_i, rx_remote_pin2_i, rx_remote_pin3_i,
                      rx_lock_i, rx_pass_i, rx_frame_valid_i,
                      rx_line_valid_i, frame_sync_signal_i, tx_frame_valid_i,
                      tx_line_valid_i, tx_synced_i, tx_interrupt_i};

    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            sync_q1_r <= '0;
            sync_q2_r <= '0;
        end else begin
            sync_q1_r <= sync_in;
            sync_q2_r <= sync_q1_r;
        end
    end

    logic [3:0] s_en;
    logic [3:0] s_psel;
    logic [3:0] s_rp0;
    logic [3:0] s_rp1;
    logic [3:0] s_rp2;
    logic [3:0] s_rp3;
    logic [3:0] s_lock;
    logic [3:0] s_pass;
    logic [3:0] s_fv;
    logic [3:0] s_lv;
    logic       s_fs;
    logic       s_tfv;
    logic       s_tlv;
    logic       s_tsync;
    logic       s_tirq;

    assign {s_en, s_psel, s_rp0, s_rp1, s_rp2, s_rp3, s_lock, s_pass,
            s_fv, s_lv, s_fs, s_tfv, s_tlv, s_tsync, s_tirq} = sync_q2_r;

    // ****************************************
    // Source selection
    // ****************************************
    function automatic logic rx_pick(input logic [2:0] sel,
                                     input logic [1:0] port,
                                     input logic [3:0] p0,
                                     input logic [3:0] p1,
                                     input logic [3:0] p2,
                                     input logic [3:0] p3,
                                     input logic [3:0] lk,
                                     input logic [3:0] ps,
                                     input logic [3:0] fv,
                                     input logic [3:0] lv);
        logic r;
        r = 1'b0;
        unique case (sel)
            3'h0: r = p0[port];
            3'h1: r = p1[port];
            3'h2: r = p2[port];
            3'h3: r = p3[port];
            3'h4: r = lk[port];
            3'h5: r = ps[port];
            3'h6: r = fv[port];
            3'h7: r = lv[port];
        endcase
        return r;
    endfunction

    logic rx_value;
    logic dev_value;
    logic tx_value;
    logic mux_value;

    assign rx_value = rx_pick(pin7_data_select,
                              pin7_output_control_r[`PIN7_SRC_LSB+1:
                                                    `PIN7_SRC_LSB],
                              s_rp0, s_rp1, s_rp2, s_rp3,
                              s_lock, s_pass, s_fv, s_lv);

    // Reserved selections drive a quiet low
    always_comb begin
        dev_value = 1'b0;
        unique case (pin7_data_select)
            3'h0: dev_value = pin7_local_value;
            3'h1: dev_value = |(s_lock & s_en);
            3'h2: dev_value = &(s_lock | ~s_en);
            3'h3: dev_value = &(s_pass | ~s_en);
            3'h4: dev_value = s_fs;
            default: dev_value = 1'b0;
        endcase
    end

    always_comb begin
        tx_value = 1'b0;
        unique case (pin7_data_select)
            3'h0: tx_value = &(s_pass | ~s_psel);
            3'h1: tx_value = |(s_pass & s_psel);
            3'h2: tx_value = s_tfv;
            3'h3: tx_value = s_tlv;
            3'h4: tx_value = s_tsync;
            3'h5: tx_value = s_tirq;
            default: tx_value = 1'b0;
        endcase
    end

    always_comb begin
        mux_value = 1'b0;
        unique case (pin7_source_group)
            pin7_pkg::SRC_RX0,
            pin7_pkg::SRC_RX1,
            pin7_pkg::SRC_RX2,
            pin7_pkg::SRC_RX3: mux_value = rx_value;
            pin7_pkg::SRC_DEV: mux_value = dev_value;
            pin7_pkg::SRC_TX:  mux_value = tx_value;
            default:           mux_value = 1'b0;
        endcase
    end

    // ****************************************
    // Pin drive
    // ****************************************
    // Registered so the pin never glitches on mux decode
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            general_pin_seven_o    <= 1'b0;
            general_pin_seven_oe_o <= 1'b0;
        end else begin
            general_pin_seven_o <= pin7_output_enable & mux_value;
            general_pin_seven_oe_o <= pin7_output_enable;
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    AST_RESET_ZERO: assert property (
        @(posedge core_clk_i) $rose(arst_n_i) |->
            pin7_output_control_r == 8'h00 && !general_pin_seven_oe_o)
        else $error("control not zero after reset");

    AST_READBACK: assert property (
        @(posedge core_clk_i) disable iff (!arst_n_i)
        reg_read_i && ctl_hit |=>
            reg_rdata_o == $past(pin7_output_control_r))
        else $error("readback mismatch");

    AST_OE_FOLLOWS: assert property (
        @(posedge core_clk_i) disable iff (!arst_n_i)
        general_pin_seven_oe_o == $past(pin7_output_control_r[0]))
        else $error("output enable not from bit 0");

    AST_QUIET_OFF: assert property (
        @(posedge core_clk_i) disable iff (!arst_n_i)
        !general_pin_seven_oe_o |-> !general_pin_seven_o)
        else $error("pin driven while disabled");

    AST_LOCAL_VAL: assert property (
        @(posedge core_clk_i) disable iff (!arst_n_i)
        pin7_output_control_r[7:2] == 6'h04 && pin7_output_enable |=>
            general_pin_seven_o == $past(pin7_local_value))
        else $error("local value not driven");

    AST_RX_LOCK: assert property (
        @(posedge core_clk_i) disable iff (!arst_n_i)
        pin7_output_enable && pin7_data_select == 3'h4 &&
        !pin7_output_control_r[4] |=>
            general_pin_seven_o ==
            $past(s_lock[pin7_output_control_r[3:2]]))
        else $error("rx lock not driven");

    AST_RX_PIN0: assert property (
        @(posedge core_clk_i) disable iff (!arst_n_i)
        pin7_output_enable && pin7_data_select == 3'h0 &&
        !pin7_output_control_r[4] |=>
            general_pin_seven_o == $past(s_rp0[pin7_output_control_r[3:2]]))
        else $error("remote pin 0 not driven");

    AST_DEV_FS: assert property (
        @(posedge core_clk_i) disable iff (!arst_n_i)
        pin7_output_enable && pin7_output_control_r[7:2] == 6'h24 |=>
            general_pin_seven_o == $past(s_fs))
        else $error("frame sync not driven");

    AST_TX_SYNC: assert property (
        @(posedge core_clk_i) disable iff (!arst_n_i)
        pin7_output_enable && pin7_output_control_r[7:2] == 6'h26 |=>
            general_pin_seven_o == $past(s_tsync))
        else $error("sync flag not driven");

    AST_TX_RSV: assert property (
        @(posedge core_clk_i) disable iff (!arst_n_i)
        pin7_output_control_r[7:2] == 6'h3e |=> !general_pin_seven_o)
        else $error("reserved select not low");

    AST_RSV_SOURCE: assert property (
        @(posedge core_clk_i) disable iff (!arst_n_i)
        pin7_output_control_r[4:2] == 3'b101 ||
        pin7_output_control_r[4:2] == 3'b111 |=> !general_pin_seven_o)
        else $error("reserved source not low");

    AST_RX_LINE: assert property (
        @(posedge core_clk_i) disable iff (!arst_n_i)
        pin7_output_enable && pin7_data_select == 3'h7 &&
        !pin7_output_control_r[4] |=>
            general_pin_seven_o ==
            $past(s_lv[pin7_output_control_r[3:2]]))
        else $error("rx line valid not driven");

    AST_TX_IRQ: assert property (
        @(posedge core_clk_i) disable iff (!arst_n_i)
        pin7_output_enable && pin7_output_control_r[7:2] == 6'h2e |=>
            general_pin_seven_o == $past(s_tirq))
        else $error("transmit interrupt not driven");

    COV_WRITE: cover property (@(posedge core_clk_i)
        reg_write_i && ctl_hit);
    COV_ENABLED: cover property (@(posedge core_clk_i)
        $rose(general_pin_seven_oe_o));
    COV_TX_IRQ: cover property (@(posedge core_clk_i)
        pin7_output_control_r[7:2] == 6'h2e && general_pin_seven_o);
    COV_READ: cover property (@(posedge core_clk_i) rd_hit_r);

endmodule

// file: core/pin7_regs.svh
`ifndef PIN7_REGS_SVH
`define PIN7_REGS_SVH

// Register map
`define PIN7_CTL_ADDR      8'h17
`define PIN7_CTL_RESET     8'h00

// Field positions in the control register
`define PIN7_SEL_MSB       7
`define PIN7_SEL_LSB       5
`define PIN7_SRC_MSB       4
`define PIN7_SRC_LSB       2
`define PIN7_VAL_BIT       1
`define PIN7_EN_BIT        0

`endif

// file: core/pin7_pkg.sv
package pin7_pkg;

    typedef enum logic [2:0] {
        SRC_RX0    = 3'b000,
        SRC_RX1    = 3'b001,
        SRC_RX2    = 3'b010,
        SRC_RX3    = 3'b011,
        SRC_DEV    = 3'b100,
        SRC_RSV5   = 3'b101,
        SRC_TX     = 3'b110,
        SRC_RSV7   = 3'b111
    } source_group_e;

    typedef logic [2:0] data_select_t;

endpackage

// file: tb/pin_observer.sv
`timescale 1ns/1ns
module pin_observer (
    input  wire logic clk_i,
    input  wire logic pin_i,
    input  wire logic oe_i,
    output logic      level_o
);
    logic float_r = 1'b0;

    // No pull on the wire: a released pin toggles, so a stale value can't pass
    always_ff @(posedge clk_i) begin
        float_r <= ~float_r;
    end

    assign level_o = oe_i ? pin_i : float_r;
endmodule

// file: tb/tb_top.sv
`timescale 1ns/1ns
module tb_top;
    logic       clk   = 1'b0;
    logic       rst_n = 1'b0;
    logic [7:0] addr  = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic       wr    = 1'b0;
    logic       rd    = 1'b0;
    logic [7:0] rdata;
    logic [3:0] en    = 4'h0;
    logic [3:0] psel  = 4'h0;
    logic [3:0] rxv [8] = '{default: 4'h0};
    logic [4:0] misc  = 5'h00;
    logic       pin;
    logic       oe;
    logic       level;
    logic [3:0] pat [3] = '{4'h0, 4'h5, 4'hf};
    int         n_mismatch = 0;
    int         samples_checked = 0;

    always #25 clk = ~clk;

    general_pin_seven_output_source_mux dut_u (
        .core_clk_i(clk), .arst_n_i(rst_n), .reg_addr_i(addr),
        .reg_wdata_i(wdata), .reg_write_i(wr), .reg_read_i(rd),
        .reg_rdata_o(rdata), .port_enable_i(en), .pass_select_i(psel),
        .rx_remote_pin0_i(rxv[0]), .rx_remote_pin1_i(rxv[1]),
        .rx_remote_pin2_i(rxv[2]), .rx_remote_pin3_i(rxv[3]),
        .rx_lock_i(rxv[4]), .rx_pass_i(rxv[5]),
        .rx_frame_valid_i(rxv[6]), .rx_line_valid_i(rxv[7]),
        .frame_sync_signal_i(misc[4]), .tx_frame_valid_i(misc[3]),
        .tx_line_valid_i(misc[2]), .tx_synced_i(misc[1]),
        .tx_interrupt_i(misc[0]), .general_pin_seven_o(pin),
        .general_pin_seven_oe_o(oe));

    pin_observer obs_u (.clk_i(clk), .pin_i(pin), .oe_i(oe), .level_o(level));

    // ****************
    // Shared tasks
    // ****************
    task chk(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task rd_reg(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk(rdata, exp);
    endtask

    function automatic logic ref_pin(input logic [7:0] c);
        logic [2:0] s;
        s = c[7:5];
        if (c[0] == 1'b0) return 1'b0;
        case (c[4:2])
            3'b000, 3'b001, 3'b010, 3'b011: return rxv[s][c[3:2]];
            3'b100: case (s)
                3'd0: return c[1];
                3'd1: return |(rxv[4] & en);
                3'd2: return &(rxv[4] | ~en);
                3'd3: return &(rxv[5] | ~en);
                3'd4: return misc[4];
                default: return 1'b0;
            endcase
            3'b110: case (s)
                3'd0: return &(rxv[5] | ~psel);
                3'd1: return |(rxv[5] & psel);
                3'd2: return misc[3];
                3'd3: return misc[2];
                3'd4: return misc[1];
                3'd5: return misc[0];
                default: return 1'b0;
            endcase
            default: return 1'b0;
        endcase
    endfunction

    // Waits past the three-edge input path, not just the two-edge write path
    task apply(input logic [7:0] c);
        wr_reg(8'h17, c);
        repeat (4) @(posedge clk);
        #1;
        chk({6'h0, oe, oe ? level : pin},
            {6'h0, c[0], ref_pin(c)});
    endtask

    // ****************
    // Scenarios
    // ****************
    task t_reset;
        rd_reg(8'h17, 8'h00);
        chk({6'h0, oe, pin}, 8'h00);
    endtask

    task t_regs;
        wr_reg(8'h17, 8'ha6);
        rd_reg(8'h17, 8'ha6);
        wr_reg(8'h16, 8'hff);
        rd_reg(8'h17, 8'ha6);
        rd_reg(8'h16, 8'h00);
    endtask

    task t_rx;
        for (int p = 0; p < 4; p++) begin
            for (int s = 0; s < 8; s++) begin
                @(posedge clk);
                for (int k = 0; k < 8; k++) begin
                    rxv[k] <= (k == s) ? 4'h1 << p : ~(4'h1 << p);
                end
                apply({s[2:0], 1'b0, p[1:0], 2'b01});
                @(posedge clk);
                for (int k = 0; k < 8; k++) begin
                    rxv[k] <= ~rxv[k];
                end
                apply({s[2:0], 1'b0, p[1:0], 2'b01});
            end
        end
    endtask

    task t_dev;
        for (int i = 0; i < 3; i++) begin
            for (int j = 0; j < 3; j++) begin
                @(posedge clk);
                en     <= pat[i];
                rxv[4] <= pat[j];
                rxv[5] <= ~pat[j];
                misc   <= {pat[j][0], 4'h0};
                for (int c = 0; c < 16; c++) begin
                    apply({c[3:1], 3'b100, c[0], 1'b1});
                end
            end
        end
    endtask

    task t_tx;
        for (int i = 0; i < 3; i++) begin
            for (int j = 0; j < 3; j++) begin
                @(posedge clk);
                psel   <= pat[i];
                rxv[5] <= pat[j];
                misc   <= {1'b0, pat[j] ^ 4'h3};
                for (int s = 0; s < 8; s++) begin
                    apply({s[2:0], 3'b110, 2'b01});
                end
            end
        end
    endtask

    task t_rsv;
        @(posedge clk);
        en   <= 4'hf;
        psel <= 4'hf;
        misc <= 5'h1f;
        for (int k = 0; k < 8; k++) begin
            rxv[k] <= 4'hf;
        end
        for (int c = 0; c < 32; c++) begin
            apply({c[4:2], c[1] ? 3'b111 : 3'b101, c[0], 1'b1});
        end
        for (int c = 0; c < 64; c++) begin
            apply({c[5:0], 2'b10});
        end
    endtask

    // Reset in mid-run must clear a live, driving configuration
    task t_rearm;
        wr_reg(8'h17, 8'h13);
        repeat (2) @(posedge clk);
        #1;
        chk({6'h0, oe, pin}, 8'h03);
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
    endtask

    task give_verdict;
        $display("checks=%0d mismatches=%0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    initial begin
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        t_regs();
        t_rx();
        t_dev();
        t_tx();
        t_rsv();
        t_rearm();
        give_verdict();
    end

    // About 2400 cycles are expected; over eight times that means a hang
    initial begin
        #(20000 * 50);
        n_mismatch++;
        give_verdict();
    end
endmodule
